// *** asrm_pkg.sv ***
// Purpose: Shared constants and types for the angle sensor register map.
// Assumes: 14-bit register addresses and 14-bit register data.
// Notes:   Offsets, bit positions, reset values and the burn cycle count live here.
`default_nettype none
package asrm_pkg;

   localparam int ADDR_W  = 14;
   localparam int DATA_W  = 14;
   localparam int FRAME_W = 16;
   localparam int NV_REGS = 4;

   // Register offsets.
   localparam logic [13:0] OFF_NULL      = 14'h0000;
   localparam logic [13:0] OFF_ERR_FLAGS = 14'h0001;
   localparam logic [13:0] OFF_FUSE_CTL  = 14'h0003;
   localparam logic [13:0] OFF_ZPOS_HI   = 14'h0016;
   localparam logic [13:0] OFF_ZPOS_LO   = 14'h0017;
   localparam logic [13:0] OFF_CFG_PRI   = 14'h0018;
   localparam logic [13:0] OFF_CFG_SEC   = 14'h0019;
   localparam logic [13:0] OFF_DIAG      = 14'h3ffc;
   localparam logic [13:0] OFF_MAGNITUDE = 14'h3ffd;
   localparam logic [13:0] OFF_RAW_ANG   = 14'h3ffe;
   localparam logic [13:0] OFF_COMP_ANG  = 14'h3fff;

   // Frame field positions.
   localparam int FRM_PARITY = 15;
   localparam int FRM_READ   = 14;
   localparam int FRM_EF     = 14;

   // Error flag bit positions.
   localparam int ERR_FRAME  = 0;
   localparam int ERR_BADCMD = 1;
   localparam int ERR_PARITY = 2;

   // Fuse-burn control bit positions.
   localparam int FB_ENABLE = 0;
   localparam int FB_RELOAD = 2;
   localparam int FB_START  = 3;
   localparam int FB_VERIFY = 6;

   // Diagnostics bit positions and gain limits.
   localparam int DG_LOOP_DONE = 8;
   localparam int DG_OVERFLOW  = 9;
   localparam int DG_STRONG    = 10;
   localparam int DG_WEAK      = 11;
   localparam logic [7:0] GAIN_MAX = 8'hff;
   localparam logic [7:0] GAIN_MIN = 8'h00;

   // Non-volatile register indices and bit positions.
   localparam int NV_ZHI = 0;
   localparam int NV_ZLO = 1;
   localparam int NV_CP  = 2;
   localparam int NV_CS  = 3;
   localparam int ZLO_STRONG_EN = 6;
   localparam int ZLO_WEAK_EN   = 7;
   localparam int CP_FIXED      = 0;
   localparam int CP_DIR        = 2;
   localparam int CP_PIN_SEL    = 3;
   localparam int CP_COMP_OFF   = 4;
   localparam int CP_BINARY     = 5;
   localparam int CP_SRC_RAW    = 6;
   localparam int CP_PW_EN      = 7;

   // Reset values and bit counter limits.
   localparam logic [3:0][7:0] NV_RESET   = {8'h00, 8'h01, 8'h00, 8'h00};
   localparam logic [2:0]      ERR_RESET  = 3'h0;
   localparam logic [13:0]     RESP_RESET = 14'h0000;
   localparam logic [4:0]      CNT_FULL   = 5'h1f;
   localparam logic [4:0]      CNT_FRAME  = 5'h10;

   // Fuse burn duration.
   localparam int CLK_PERIOD_NS = 10;
   localparam int BURN_TIME_NS  = 1000;
   localparam int BURN_CYCLES   = (BURN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] BURN_LAST = 8'(BURN_CYCLES - 1);

   typedef enum logic {ST_CMD, ST_WDATA} asrm_state_t;

endpackage
`default_nettype wire

// *** asrm_fuse_if.sv ***
// Purpose: Carries fuse requests and reload data between register map and fuse store.
// Assumes: Both ends run on mclk.
// Notes:   The register side owns the soft values; the fuse side owns loads.
`timescale 1ns/1ps
`default_nettype none
interface asrm_fuse_if;
   logic [3:0][7:0] softVal;
   logic            burnReq;
   logic            burnEnable;
   logic            reloadReq;
   logic            busy;
   logic            loadStb;
   logic [3:0][7:0] loadVal;

   modport regs (output softVal, output burnReq, output burnEnable, output reloadReq,
                 input busy, input loadStb, input loadVal);
   modport fuse (input softVal, input burnReq, input burnEnable, input reloadReq,
                 output busy, output loadStb, output loadVal);
endinterface
`default_nettype wire

// *** asrm_fuse.sv ***
// Purpose: One-time fuse store for the non-volatile registers.
// Assumes: fusePorN is the power-on reset; arst_n is the hardware reset.
// Notes:   Fuse content ignores arst_n so that it survives a hardware reset.
`timescale 1ns/1ps
`default_nettype none
module asrm_fuse
   import asrm_pkg::*;
(
   // Clock and resets
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic fusePorN,
   // Register side
   asrm_fuse_if.fuse fuseIf
);

   logic [7:0] fuseMem_q [NV_REGS];
   logic       burned_q;
   logic       busy_q;
   logic [7:0] burnCnt_q;
   logic       startup_q;
   logic       loadStb_q;
   logic       burnGo;
   logic       commit;

   // A single burn only, and never without the enable bit.
   assign burnGo = fuseIf.burnReq && fuseIf.burnEnable && !burned_q && !busy_q;
   assign commit = busy_q && (burnCnt_q == 8'h00);

   always_ff @(posedge mclk or negedge fusePorN) begin
      if (!fusePorN) begin
         burned_q <= 1'b0;
      end else if (commit) begin
         burned_q <= 1'b1;
      end
   end

   for (genvar gi = 0; gi < NV_REGS; gi++) begin : g_mem
      always_ff @(posedge mclk or negedge fusePorN) begin
         if (!fusePorN) begin
            fuseMem_q[gi] <= NV_RESET[gi];
         end else if (commit) begin
            fuseMem_q[gi] <= fuseIf.softVal[gi];
         end
      end
      assign fuseIf.loadVal[gi] = fuseMem_q[gi];
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         busy_q    <= 1'b0;
         burnCnt_q <= 8'h00;
      end else if (burnGo) begin
         busy_q    <= 1'b1;
         burnCnt_q <= BURN_LAST;
      end else if (busy_q) begin
         busy_q    <= !commit;
         burnCnt_q <= burnCnt_q - 8'h01;
      end
   end

   // After every hardware reset the programmed values are restored.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         startup_q <= 1'b1;
         loadStb_q <= 1'b0;
      end else begin
         startup_q <= 1'b0;
         loadStb_q <= startup_q || fuseIf.reloadReq;
      end
   end

   assign fuseIf.busy    = busy_q;
   assign fuseIf.loadStb = loadStb_q;

endmodule // asrm_fuse
`default_nettype wire

// *** asrm_regmap.sv ***
// Purpose: Register map of a rotary angle sensor behind a mode-1 serial slave.
// Assumes: csN, sclk and mosi come from the host and are sampled by mclk.
// Notes:   sclk must stay well below mclk/8 so that every edge is seen.
//
// Contract
// - Each register is selected by a full 14-bit address in the command word.
// - Address 0x3FFE returns the uncompensated angle in bits 13:0.
// - Address 0x3FFF returns the compensated angle, subject to the source bit and the compensation-off bit.
// - Reading address zero has no side effect and returns zero.
// - An access to an unmapped address sets the bad-command fault, bit 1.
// - A malformed frame sets the frame fault, bit 0.
// - Reading the error flags returns them, then clears them all.
// - The host writes the verify bit, bit 6, to check the fuse content.
// - Writing 1 to bit 3 of fuse control starts a burn cycle.
// - Writing 1 to bit 2 reloads the soft registers from the fuses.
// - No burn proceeds unless the burn-enable bit 0 is set.
// - Diagnostics bit 11 shows the weak field while gain equals 0xFF.
// - Diagnostics bit 10 shows the strong field while gain equals 0x00.
// - Diagnostics bits 9, 8 and 7:0 give overflow, loop done and gain.
// - Settings bit 6 picks what 0x3FFF returns: 0 compensated unless bit 4 is set, 1 raw.
// - Non-volatile registers are soft writable and lose soft values on reset.
// - Fuses burn once, survive hardware reset, are restored, never overwritten.
// - Zero position: upper 8 bits at 0x0016, lower 6 bits at 0x0017.
// - Low zero register bits 6 and 7 enable strong and weak field errors.
// - Settings bit 0 reads 1; bit 1 presets 0 and the host keeps it.
// - Settings bit 3 selects the pulse-width output pin.
// - Settings bit 4 set turns latency compensation off.
// - Settings bit 5 picks binary pulse count; bit 2 sets rotation direction.
// - Settings bit 7 enables the pulse-width output.
// - A command word with wrong even parity sets the parity fault.
// - Read results are captured at chip-select rise and sent next frame.
`timescale 1ns/1ps
`default_nettype none
module asrm_regmap
   import asrm_pkg::*;
(
   // Clock and resets
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        fusePorN,
   // Serial link pins
   input  wire logic        csN,
   input  wire logic        sclk,
   input  wire logic        mosi,
   output logic             miso,
   output logic             misoOe,
   // Measurement inputs
   input  wire logic [7:0]  gainLevel,
   input  wire logic        angleCalcOverflow,
   input  wire logic        offsetLoopDone,
   input  wire logic [13:0] magnitude,
   input  wire logic [13:0] rawAngleValue,
   input  wire logic [13:0] compAngleValue,
   // Settings and field error outputs
   output logic [13:0]      zeroPosition,
   output logic             strongErrEnable,
   output logic             weakErrEnable,
   output logic             rotationDir,
   output logic             pulseWidthPinSelect,
   output logic             latencyCompOff,
   output logic             pulseBaseBinary,
   output logic             pulseWidthOutEnable,
   output logic [7:0]       configSecondary,
   output logic             fieldErrorFlag
);

   asrm_fuse_if fuseIf ();

   // Link synchronisers: bit 0 feeds only bit 1.
   logic [2:0]      csSync_q;
   logic [2:0]      sclkSync_q;
   logic [1:0]      mosiSync_q;

   logic [15:0]     shIn_q;
   logic [15:0]     shOut_q;
   logic [4:0]      bitCnt_q;
   asrm_state_t     state_q;
   logic [13:0]     wrAddr_q;
   logic [13:0]     respData_q;
   logic            ef_q;
   logic            reloadResp_q;
   logic [2:0]      errFlags_q;
   logic [2:0]      errFlags_d;
   logic [3:0][7:0] nvReg_q;
   logic            burnVerify_q;
   logic            burnEnable_q;
   logic            burnReq_q;
   logic            reloadReq_q;
   logic            miso_q;
   logic            misoOe_q;
   logic            fieldErr_q;

   wire logic        csLow;
   wire logic        csFall;
   wire logic        csRise;
   wire logic        sclkRise;
   wire logic        sclkFall;
   wire logic        frameOk;
   wire logic        parOk;
   wire logic [13:0] rxAddr;
   wire logic        rxRead;
   wire logic        rxValid;
   wire logic        cmdOk;
   wire logic        dataOk;
   wire logic        setFrame;
   wire logic        setParity;
   wire logic        setBad;
   wire logic        clrErr;
   wire logic        wrStb;
   wire logic [7:0]  wrData;
   wire logic [13:0] addrSel;
   wire logic        weakField;
   wire logic        strongField;
   wire logic [13:0] diagWord;
   logic      [13:0] rdData;

   function automatic logic isValidAddr(input logic [13:0] a);
      return (a == OFF_NULL) || (a == OFF_ERR_FLAGS) || (a == OFF_FUSE_CTL) ||
             (a == OFF_ZPOS_HI) || (a == OFF_ZPOS_LO) || (a == OFF_CFG_PRI) ||
             (a == OFF_CFG_SEC) || (a == OFF_DIAG) || (a == OFF_MAGNITUDE) ||
             (a == OFF_RAW_ANG) || (a == OFF_COMP_ANG);
   endfunction

   // Sampling and edge detection of the link.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         csSync_q   <= 3'h7;
         sclkSync_q <= 3'h0;
         mosiSync_q <= 2'h0;
      end else begin
         csSync_q   <= {csSync_q[1:0], csN};
         sclkSync_q <= {sclkSync_q[1:0], sclk};
         mosiSync_q <= {mosiSync_q[0], mosi};
      end
   end

   assign csLow    = !csSync_q[1];
   assign csFall   = !csSync_q[1] && csSync_q[2];
   assign csRise   = csSync_q[1] && !csSync_q[2];
   assign sclkRise = sclkSync_q[1] && !sclkSync_q[2] && csLow;
   assign sclkFall = !sclkSync_q[1] && sclkSync_q[2] && csLow;

   // Frame decode at chip-select rise.
   assign frameOk   = (bitCnt_q == CNT_FRAME);
   assign parOk     = !(^shIn_q);
   assign rxAddr    = shIn_q[13:0];
   assign rxRead    = shIn_q[FRM_READ];
   assign rxValid   = isValidAddr(rxAddr);
   assign cmdOk     = csRise && frameOk && parOk && (state_q == ST_CMD);
   assign dataOk    = csRise && frameOk && parOk && (state_q == ST_WDATA) && !rxRead;
   assign setFrame  = csRise && (!frameOk ||
                      (parOk && (state_q == ST_WDATA) && rxRead));
   assign setParity = csRise && frameOk && !parOk;
   assign setBad    = cmdOk && !rxValid;
   assign clrErr    = cmdOk && rxRead && (rxAddr == OFF_ERR_FLAGS);
   assign wrStb     = dataOk;
   assign wrData    = shIn_q[7:0];

   // Set wins over clear, so a fault in the clearing frame is kept.
   assign errFlags_d = (clrErr ? ERR_RESET : errFlags_q) |
                       {setParity, setBad, setFrame};

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         errFlags_q <= ERR_RESET;
      end else begin
         errFlags_q <= errFlags_d;
      end
   end

   // Shift registers: mode 1, sample on falling, drive on rising.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         shIn_q   <= 16'h0000;
         bitCnt_q <= 5'h00;
      end else if (csFall) begin
         bitCnt_q <= 5'h00;
      end else if (sclkFall) begin
         shIn_q   <= {shIn_q[14:0], mosiSync_q[1]};
         bitCnt_q <= (bitCnt_q == CNT_FULL) ? CNT_FULL : bitCnt_q + 5'h01;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         shOut_q <= 16'h0000;
         miso_q  <= 1'b0;
      end else if (csFall) begin
         shOut_q <= {^{ef_q, respData_q}, ef_q, respData_q};
      end else if (sclkRise) begin
         miso_q  <= shOut_q[15];
         shOut_q <= {shOut_q[14:0], 1'b0};
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         misoOe_q <= 1'b0;
      end else begin
         misoOe_q <= csLow;
      end
   end

   // A valid write command waits for its data frame.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q  <= ST_CMD;
         wrAddr_q <= OFF_NULL;
      end else if (csRise) begin
         state_q  <= (cmdOk && !rxRead && rxValid) ? ST_WDATA : ST_CMD;
         if (cmdOk) begin
            wrAddr_q <= rxAddr;
         end
      end
   end

   // Response capture; after a write the new content is caught one cycle later.
   assign addrSel = reloadResp_q ? wrAddr_q : rxAddr;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         respData_q   <= RESP_RESET;
         ef_q         <= 1'b0;
         reloadResp_q <= 1'b0;
      end else begin
         reloadResp_q <= dataOk;
         if (csRise) begin
            ef_q <= setFrame || setParity || setBad;
         end
         if (cmdOk) begin
            respData_q <= rxValid ? rdData : RESP_RESET;
         end else if (reloadResp_q) begin
            respData_q <= rdData;
         end
      end
   end

   // Diagnostics word.
   assign weakField   = (gainLevel == GAIN_MAX);
   assign strongField = (gainLevel == GAIN_MIN);
   assign diagWord    = {2'b00, weakField, strongField, angleCalcOverflow,
                         offsetLoopDone, gainLevel};

   // Read multiplexer; undefined bits read zero.
   always_comb begin
      if (addrSel == OFF_ERR_FLAGS) begin
         rdData = {11'h000, errFlags_q};
      end else if (addrSel == OFF_FUSE_CTL) begin
         rdData = {7'h00, burnVerify_q, 2'b00, fuseIf.busy, 2'b00, burnEnable_q};
      end else if (addrSel == OFF_ZPOS_HI) begin
         rdData = {6'h00, nvReg_q[NV_ZHI]};
      end else if (addrSel == OFF_ZPOS_LO) begin
         rdData = {6'h00, nvReg_q[NV_ZLO]};
      end else if (addrSel == OFF_CFG_PRI) begin
         rdData = {6'h00, nvReg_q[NV_CP][7:1], 1'b1};
      end else if (addrSel == OFF_CFG_SEC) begin
         rdData = {6'h00, nvReg_q[NV_CS]};
      end else if (addrSel == OFF_DIAG) begin
         rdData = diagWord;
      end else if (addrSel == OFF_MAGNITUDE) begin
         rdData = magnitude;
      end else if (addrSel == OFF_RAW_ANG) begin
         rdData = rawAngleValue;
      end else if (addrSel == OFF_COMP_ANG) begin
         // With compensation off, the compensated view falls back to raw.
         rdData = (nvReg_q[NV_CP][CP_SRC_RAW] || nvReg_q[NV_CP][CP_COMP_OFF]) ?
                  rawAngleValue : compAngleValue;
      end else begin
         rdData = RESP_RESET;
      end
   end

   // Non-volatile registers: soft writes, lost on reset, reloaded from fuses.
   for (genvar gi = 0; gi < NV_REGS; gi++) begin : g_nv
      always_ff @(posedge mclk or negedge arst_n) begin
         if (!arst_n) begin
            nvReg_q[gi] <= NV_RESET[gi];
         end else if (fuseIf.loadStb) begin
            nvReg_q[gi] <= fuseIf.loadVal[gi];
         end else if (wrStb && (wrAddr_q == OFF_ZPOS_HI + 14'(gi))) begin
            nvReg_q[gi] <= wrData;
         end
      end
   end

   // Fuse-burn control; start and reload act as one-cycle requests.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         burnVerify_q <= 1'b0;
         burnEnable_q <= 1'b0;
         burnReq_q    <= 1'b0;
         reloadReq_q  <= 1'b0;
      end else begin
         burnReq_q   <= 1'b0;
         reloadReq_q <= 1'b0;
         if (wrStb && (wrAddr_q == OFF_FUSE_CTL)) begin
            burnVerify_q <= wrData[FB_VERIFY];
            burnEnable_q <= wrData[FB_ENABLE];
            burnReq_q    <= wrData[FB_START];
            // Verify reloads the fused values so the host can compare them.
            reloadReq_q  <= wrData[FB_RELOAD] || wrData[FB_VERIFY];
         end
      end
   end

   assign fuseIf.softVal    = {nvReg_q[NV_CS], nvReg_q[NV_CP][7:1], 1'b1,
                               nvReg_q[NV_ZLO], nvReg_q[NV_ZHI]};
   assign fuseIf.burnReq    = burnReq_q;
   assign fuseIf.burnEnable = burnEnable_q;
   assign fuseIf.reloadReq  = reloadReq_q;

   asrm_fuse u_fuse (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .fusePorN (fusePorN),
      .fuseIf   (fuseIf.fuse)
   );

   // Combined error flag for the output generators.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         fieldErr_q <= 1'b0;
      end else begin
         fieldErr_q <= angleCalcOverflow || !offsetLoopDone ||
                       (strongField && nvReg_q[NV_ZLO][ZLO_STRONG_EN]) ||
                       (weakField && nvReg_q[NV_ZLO][ZLO_WEAK_EN]);
      end
   end

   // Outputs.
   assign miso                = miso_q;
   assign misoOe              = misoOe_q;
   assign zeroPosition        = {nvReg_q[NV_ZHI], nvReg_q[NV_ZLO][5:0]};
   assign strongErrEnable     = nvReg_q[NV_ZLO][ZLO_STRONG_EN];
   assign weakErrEnable       = nvReg_q[NV_ZLO][ZLO_WEAK_EN];
   assign rotationDir         = nvReg_q[NV_CP][CP_DIR];
   assign pulseWidthPinSelect = nvReg_q[NV_CP][CP_PIN_SEL];
   assign latencyCompOff      = nvReg_q[NV_CP][CP_COMP_OFF];
   assign pulseBaseBinary     = nvReg_q[NV_CP][CP_BINARY];
   assign pulseWidthOutEnable = nvReg_q[NV_CP][CP_PW_EN];
   assign configSecondary     = nvReg_q[NV_CS];
   assign fieldErrorFlag      = fieldErr_q;

endmodule // asrm_regmap
`default_nettype wire

// *** asrm_checker.sv ***
// Purpose: Pin-level checks of the register map.
// Assumes: The link clock runs far below mclk/8.
// Notes:   Bound to the register map below.
`timescale 1ns/1ps
`default_nettype none
module asrm_checker (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        arst_n,
   // Link
   input wire logic        csN,
   input wire logic        sclk,
   input wire logic        miso,
   input wire logic        misoOe,
   // Levels
   input wire logic [7:0]  gainLevel,
   input wire logic        angleCalcOverflow,
   input wire logic        offsetLoopDone,
   input wire logic [13:0] zeroPosition,
   input wire logic        strongErrEnable,
   input wire logic        weakErrEnable,
   input wire logic [7:0]  configSecondary,
   input wire logic        fieldErrorFlag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   wire logic fieldCause = angleCalcOverflow | !offsetLoopDone
      | (gainLevel == 8'h00 && strongErrEnable) | (gainLevel == 8'hff && weakErrEnable);
   oe_on_a: assert property (!csN [*5] |-> misoOe) else $error("miso enable late");
   oe_off_a: assert property (csN [*5] |-> !misoOe) else $error("miso enable stuck");
   oe_start_a: assert property ($rose(misoOe) |-> !$past(csN, 2)) else $error("early on");
   oe_stop_a: assert property ($fell(misoOe) |-> $past(csN, 2)) else $error("early off");
   miso_hold_a: assert property ((!sclk && !csN) [*6] |-> $stable(miso))
      else $error("miso moved");
   field_err_a: assert property ($past(arst_n) |-> fieldErrorFlag == $past(fieldCause))
      else $error("field error flag wrong");
   zpos_keep_a: assert property (csN [*8] |-> $stable(zeroPosition))
      else $error("zero position moved");
   cfg_keep_a: assert property (csN [*8] |-> $stable({configSecondary, strongErrEnable}))
      else $error("settings moved");
   field_c: cover property ($rose(fieldErrorFlag));
   zpos_c: cover property ($changed(zeroPosition));
   frame_c: cover property ($fell(misoOe));
endmodule // asrm_checker
bind asrm_regmap asrm_checker u_asrm_checker (.*);
`default_nettype wire

// *** asrm_host.sv ***
// Purpose: Host model, a mode-1 serial master.
// Assumes: mclk at 100 MHz; link period 160 ns.
// Notes:   Link clock idles low; mosi flips when released.
`timescale 1ns/1ps
`default_nettype none
module asrm_host (
   // Clock
   input wire logic mclk,
   // Link
   output var logic csN,
   output var logic sclk,
   output var logic mosi,
   input wire logic miso
);
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // A frame shorter than 16 bits is sent only when a fault is wanted.
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge mclk) csN <= 1'b0;
      repeat (36) @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         sclk <= 1'b1;
         mosi <= tx[15 - i];
         repeat (8) @(posedge mclk);
         sclk <= 1'b0;
         rx = {rx[14:0], miso};
         repeat (8) @(posedge mclk);
      end
      csN <= 1'b1;
      mosi <= ~mosi;
      repeat (40) @(posedge mclk);
   endtask
endmodule // asrm_host
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench of the register map.
// Assumes: Host model drives the link.
// Notes:   Seeded random values with fixed corner cases.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import asrm_pkg::*;
   logic mclk = 1'b0, arst_n = 1'b0, fusePorN = 1'b0;
   logic [7:0] gainLevel = 8'h80;
   logic angleCalcOverflow = 1'b0, offsetLoopDone = 1'b1;
   logic [13:0] magnitude = 14'h0000, rawAngleValue = 14'h0000, compAngleValue = 14'h0000;
   wire logic csN, sclk, mosi, miso, misoOe, fieldErrorFlag;
   wire logic [13:0] zeroPosition;
   wire logic [7:0] configSecondary;
   wire logic strongErrEnable, weakErrEnable, rotationDir, pulseWidthPinSelect;
   wire logic latencyCompOff, pulseBaseBinary, pulseWidthOutEnable;
   int n_mismatch = 0, total_checks = 0;
   logic [15:0] rx;
   logic [13:0] d;
   logic [7:0] nv [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
   localparam logic [13:0] NVA [4] = '{OFF_ZPOS_HI, OFF_ZPOS_LO, OFF_CFG_PRI, OFF_CFG_SEC};
   asrm_regmap u_asrm_regmap (.*);
   asrm_host u_asrm_host (.*);
   always #5 mclk = ~mclk;
   function automatic logic [15:0] frm(input logic [14:0] v);
      return {^v, v};
   endfunction
   function automatic logic [13:0] diagExp();
      return {2'b00, gainLevel == GAIN_MAX, gainLevel == GAIN_MIN, angleCalcOverflow,
              offsetLoopDone, gainLevel};
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [13:0] a, input logic [13:0] v);
      u_asrm_host.xfer(frm({1'b0, a}), 16, rx);
      u_asrm_host.xfer(frm({1'b0, v}), 16, rx);
   endtask
   task automatic rd(input logic [13:0] a, input logic [13:0] exp, input string what);
      u_asrm_host.xfer(frm({1'b1, a}), 16, rx);
      u_asrm_host.xfer(frm({1'b1, OFF_NULL}), 16, rx);
      chk(what, {2'b10, exp}, {rx[15] == ^rx[14:0], 1'b0, rx[13:0]});
   endtask
   task automatic hwReset();
      arst_n <= 1'b0;
      repeat (20) @(posedge mclk);
      arst_n <= 1'b1;
      fusePorN <= 1'b1;
      repeat (10) @(posedge mclk);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #800000;
      n_mismatch++;
      results();
   end
   initial begin
      void'($urandom(42902));
      hwReset();
      rd(OFF_NULL, 14'h0000, "null_access");
      rd(OFF_DIAG, 14'h0180, "diagnostics reset");
      rd(OFF_ERR_FLAGS, 14'h0000, "error_flags");
      rd(OFF_FUSE_CTL, 14'h0000, "fuse_burn_control");
      for (int i = 0; i < 4; i++) rd(NVA[i], {6'h00, nv[i]}, "nv reset");
      $display("test done: reset values");
      for (int k = 0; k < 8; k++) begin
         d = 14'($urandom);
         if (k % 4 == 2) d[1] = 1'b0;
         wr(NVA[k % 4], d);
         nv[k % 4] = d[7:0] | 8'(k % 4 == 2);
         rd(NVA[k % 4], {6'h00, nv[k % 4]}, "soft register");
         chk("zero position", {2'b00, nv[0], nv[1][5:0]}, {2'b00, zeroPosition});
         chk("setting pins", {1'b0, nv[1][7:6], nv[2][7], nv[2][5:2], nv[3]},
             {1'b0, weakErrEnable, strongErrEnable, pulseWidthOutEnable, pulseBaseBinary,
              latencyCompOff, pulseWidthPinSelect, rotationDir, configSecondary});
      end
      $display("test done: soft registers");
      for (int k = 0; k < 6; k++) begin
         gainLevel <= k == 0 ? GAIN_MIN : k == 1 ? GAIN_MAX : 8'($urandom);
         angleCalcOverflow <= 1'($urandom);
         offsetLoopDone <= 1'($urandom);
         magnitude <= 14'($urandom);
         rawAngleValue <= 14'($urandom);
         compAngleValue <= 14'($urandom);
         nv[2][6] = k[0];
         nv[2][4] = k[1];
         wr(OFF_CFG_PRI, {6'h00, nv[2]});
         rd(OFF_DIAG, diagExp(), "diagnostics_gain");
         rd(OFF_MAGNITUDE, magnitude, "vector_length");
         rd(OFF_RAW_ANG, rawAngleValue, "raw_angle");
         rd(OFF_COMP_ANG, nv[2][6] | nv[2][4] ? rawAngleValue : compAngleValue,
            "comp");
      end
      $display("test done: measurements");
      rd(14'h0002, 14'h0000, "unmapped read");
      chk("error bit", 16'h0001, {15'h0000, rx[14]});
      rd(OFF_ERR_FLAGS, 14'h0002, "bad command");
      rd(OFF_ERR_FLAGS, 14'h0000, "flags cleared");
      wr(14'h0100, 14'h0055);
      rd(OFF_ERR_FLAGS, 14'h0002, "bad write");
      u_asrm_host.xfer(frm({1'b1, OFF_NULL}) ^ 16'h8000, 16, rx);
      rd(OFF_ERR_FLAGS, 14'h0004, "parity fault");
      u_asrm_host.xfer(frm({1'b1, OFF_NULL}), 15, rx);
      rd(OFF_ERR_FLAGS, 14'h0001, "frame fault");
      $display("test done: faults");
      wr(OFF_ZPOS_HI, 14'h005a);
      wr(OFF_FUSE_CTL, 14'h0008);
      hwReset();
      rd(OFF_ZPOS_HI, 14'h0000, "burn refused");
      wr(OFF_ZPOS_HI, 14'h005a);
      wr(OFF_FUSE_CTL, 14'h0009);
      wr(OFF_ZPOS_HI, 14'h0011);
      wr(OFF_FUSE_CTL, 14'h0004);
      rd(OFF_ZPOS_HI, 14'h005a, "fuse reload");
      wr(OFF_ZPOS_HI, 14'h0033);
      wr(OFF_FUSE_CTL, 14'h0040);
      rd(OFF_ZPOS_HI, 14'h005a, "verify reload");
      wr(OFF_ZPOS_HI, 14'h0077);
      wr(OFF_FUSE_CTL, 14'h0009);
      hwReset();
      rd(OFF_ZPOS_HI, 14'h005a, "fuse kept");
      $display("test done: fuses");
      results();
   end
endmodule // tb_top
`default_nettype wire
